// File: src/isabc_regs.svh
`ifndef ISABC_REGS_SVH
`define ISABC_REGS_SVH

// Divisor choices for the bus clock strap
`define ISABC_DIV_STRAP_HI      3'h3
`define ISABC_DIV_STRAP_LO      3'h4
// Cycle lengths in bus clocks
`define ISABC_LEN_MEM16         4'h3
`define ISABC_LEN_MEM16_ZWS     4'h2
`define ISABC_LEN_IO16          4'h3
`define ISABC_LEN_B8            4'h6
`define ISABC_LEN_B8_ZWS        4'h3
`define ISABC_LEN_REFRESH       4'h3
// Standard memory window limit, address bits above 19 must be zero
`define ISABC_STD_MEM_TOP_BIT   5
`define ISABC_PG_SYNC_STAGES    2

`endif

// File: src/isabc_pkg.sv
package isabc_pkg;

    typedef enum logic [1:0] {
        ISABC_CMD_MEM_RD = 2'h0,
        ISABC_CMD_MEM_WR = 2'h1,
        ISABC_CMD_IO_RD  = 2'h2,
        ISABC_CMD_IO_WR  = 2'h3
    } isabc_cmd_t;

    typedef enum logic [1:0] {
        ISABC_SRC_CPU     = 2'h0,
        ISABC_SRC_DMA     = 2'h1,
        ISABC_SRC_REFRESH = 2'h2
    } isabc_src_t;

    typedef enum logic [5:0] {
        ISABC_ST_IDLE  = 6'h01,
        ISABC_ST_ADDR  = 6'h02,
        ISABC_ST_CMD   = 6'h04,
        ISABC_ST_WAIT  = 6'h08,
        ISABC_ST_END   = 6'h10,
        ISABC_ST_DONE  = 6'h20
    } isabc_state_t;

endpackage

// File: src/isabc_skid_buf.sv
`timescale 1ns/100ps
`default_nettype none

// Two-entry buffer: holds a word while the receiver stalls
module isabc_skid_buf #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_reg [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = clk_en && in_valid && in_ready;
    assign pop       = clk_en && out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end

    no_overflow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        count_reg <= 2'h2)
        else $error("buffer count above two");

endmodule // isabc_skid_buf

`default_nettype wire

// File: src/isabc_cycle.sv
`timescale 1ns/100ps
`default_nettype none
`include "isabc_regs.svh"

module isabc_cycle
    import isabc_pkg::*;
(
    // Clock, enable, reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    // Power good and straps
    input  wire logic        power_good_input,
    input  wire logic        ext_dma_strap_en,
    input  wire logic        tc_strap_in,
    // Request from the bridge core
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire isabc_cmd_t  req_cmd,
    input  wire isabc_src_t  req_src,
    input  wire logic [23:0] req_addr,
    input  wire logic [1:0]  req_byte_en,
    input  wire logic [15:0] req_wdata,
    // Read data toward the bridge core
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic      [15:0] rsp_rdata,
    // External ISA master owns the bus
    input  wire logic        ext_master_dram,
    input  wire logic        ext_master_ready,
    // Error reporting
    input  wire logic        nmi_chk_enable,
    output logic             nmi_out,
    // Bus clock pin
    input  wire logic        sysclk_in,
    output logic             sysclk_out,
    output logic             sysclk_oe,
    // Address and control pins
    output logic             bale_out,
    output logic             aen_out,
    output logic             aen_oe,
    output logic      [19:0] sa_out,
    output logic      [23:17] la_out,
    output logic             addr_oe,
    output logic             sbhe_n_out,
    output logic             refresh_n_out,
    // Commands
    output logic             memr_n_out,
    output logic             memw_n_out,
    output logic             smemr_n_out,
    output logic             smemw_n_out,
    output logic             ior_n_out,
    output logic             iow_n_out,
    output logic             cmd_oe,
    // Slave responses
    input  wire logic        iochrdy_in,
    output logic             iochrdy_out,
    output logic             iochrdy_oe,
    input  wire logic        iocs16_n_in,
    input  wire logic        zerows_n_in,
    input  wire logic        iochk_n_in,
    output logic             memcs16_n_out,
    output logic             memcs16_n_oe,
    // Data lanes
    input  wire logic [15:0] sd_in,
    output logic      [15:0] sd_out,
    output logic             sd_oe
);
    // Synchronisers for power good, the bus clock, the tc strap and the slave pin inputs
    logic [1:0] pg_s, clk_s, tc_s, rdy_s, cs16_s, zws_s, chk_s;
    logic [15:0] sd_s1_reg, sd_s2_reg;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pg_s   <= 2'h0;
            clk_s  <= 2'h0;
            tc_s   <= 2'h3;
            rdy_s  <= 2'h3;
            cs16_s <= 2'h3;
            zws_s  <= 2'h3;
            chk_s  <= 2'h3;
        end else if (clk_en) begin
            pg_s   <= {pg_s[0], power_good_input};
            clk_s  <= {clk_s[0], sysclk_in};
            tc_s   <= {tc_s[0], tc_strap_in};
            rdy_s  <= {rdy_s[0], iochrdy_in};
            cs16_s <= {cs16_s[0], iocs16_n_in};
            zws_s  <= {zws_s[0], zerows_n_in};
            chk_s  <= {chk_s[0], iochk_n_in};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en) begin
            sd_s1_reg <= sd_in;
            sd_s2_reg <= sd_s1_reg;
        end
    end

    logic pg_q, pg_d_reg;
    assign pg_q = pg_s[1];

    // Straps caught on the rising edge of power good
    logic [2:0] div_reg;
    logic       ext_dma_reg;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pg_d_reg    <= 1'b0;
            div_reg     <= `ISABC_DIV_STRAP_LO;
            ext_dma_reg <= 1'b0;
        end else if (clk_en) begin
            pg_d_reg <= pg_q;
            if (pg_q && !pg_d_reg) begin
                div_reg     <= clk_s[1] ? `ISABC_DIV_STRAP_HI
                                        : `ISABC_DIV_STRAP_LO;
                ext_dma_reg <= ext_dma_strap_en && !tc_s[1];
            end
        end
    end

    // Bus clock divider
    logic [2:0] div_cnt_reg;
    logic       sclk_reg;
    logic       sclk_rise;
    assign sclk_rise = clk_en && pg_q && (div_cnt_reg == 3'h0);
    always_ff @(posedge sys_clk) begin
        if (sys_rst || !pg_q) begin
            div_cnt_reg <= 3'h0;
            sclk_reg    <= 1'b0;
        end else if (clk_en) begin
            div_cnt_reg <= (div_cnt_reg == div_reg - 3'h1) ? 3'h0
                                                         : div_cnt_reg + 3'h1;
            sclk_reg <= (div_cnt_reg < (div_reg >> 1));
        end
    end
    assign sysclk_out = sclk_reg;
    assign sysclk_oe  = pg_q;

    // Cycle sequencer, address and wait phases advance on bus clock rises
    isabc_state_t state_reg;
    isabc_cmd_t   cmd_reg;
    isabc_src_t   src_reg;
    logic [23:0]  addr_reg;
    logic [1:0]   be_reg;
    logic [15:0]  wdata_reg;
    logic [3:0]   len_reg;
    logic [3:0]   cnt_reg;
    logic         wide_reg;
    logic         rd_ready;
    logic         is_mem, is_io, is_ref, is_rd;

    assign is_ref = (src_reg == ISABC_SRC_REFRESH);
    assign is_mem = !cmd_reg[1] || is_ref;
    assign is_io  = cmd_reg[1] && !is_ref;
    assign is_rd  = !cmd_reg[0] || is_ref;
    assign req_ready = (state_reg == ISABC_ST_IDLE) && pg_q
                       && !ext_master_dram;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_reg <= ISABC_ST_IDLE;
            cmd_reg   <= ISABC_CMD_MEM_RD;
            src_reg   <= ISABC_SRC_CPU;
            addr_reg  <= 24'h000000;
            be_reg    <= 2'h0;
            wdata_reg <= 16'h0000;
            len_reg   <= 4'h0;
            cnt_reg   <= 4'h0;
            wide_reg  <= 1'b0;
        end else if (clk_en) begin
            unique case (state_reg)
                ISABC_ST_IDLE: begin
                    if (req_valid && req_ready) begin
                        cmd_reg   <= req_cmd;
                        src_reg   <= req_src;
                        addr_reg  <= req_addr;
                        be_reg    <= req_byte_en;
                        wdata_reg <= req_wdata;
                        state_reg <= ISABC_ST_ADDR;
                    end
                end
                ISABC_ST_ADDR: begin
                    if (sclk_rise) begin
                        cnt_reg   <= 4'h1;
                        state_reg <= ISABC_ST_CMD;
                    end
                end
                ISABC_ST_CMD: begin
                    // Width decided once command is out
                    wide_reg <= is_io ? !cs16_s[1]
                                      : (be_reg[1] && !is_ref);
                    if (is_ref) begin
                        len_reg <= `ISABC_LEN_REFRESH;
                    end else if (is_io && !cs16_s[1]) begin
                        len_reg <= `ISABC_LEN_IO16;
                    end else if (be_reg[1]) begin
                        len_reg <= `ISABC_LEN_MEM16;
                    end else begin
                        len_reg <= `ISABC_LEN_B8;
                    end
                    state_reg <= ISABC_ST_WAIT;
                end
                ISABC_ST_WAIT: begin
                    if (sclk_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (!zws_s[1] && !is_ref && !(is_io && wide_reg)
                            && cnt_reg + 4'h1 >= (wide_reg
                                ? `ISABC_LEN_MEM16_ZWS
                                : `ISABC_LEN_B8_ZWS)) begin
                            state_reg <= ISABC_ST_END;
                        end else if (cnt_reg + 4'h1 >= len_reg
                                     && rdy_s[1]) begin
                            state_reg <= ISABC_ST_END;
                        end
                    end
                end
                ISABC_ST_END: begin
                    if (rd_ready) begin
                        state_reg <= ISABC_ST_DONE;
                    end
                end
                ISABC_ST_DONE: begin
                    state_reg <= ISABC_ST_IDLE;
                end
                default: state_reg <= ISABC_ST_IDLE;
            endcase
        end
    end

    // Read data buffered toward the core
    logic buf_in_ready;
    logic read_end;
    assign read_end = (state_reg == ISABC_ST_END) && is_rd && !is_ref;
    assign rd_ready = !read_end || buf_in_ready;

    isabc_skid_buf #(
        .WIDTH (16)
    ) u_rd_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .in_valid  (read_end),
        .in_ready  (buf_in_ready),
        .in_data   (wide_reg ? sd_s2_reg
                             : {8'h00, be_reg[1] ? sd_s2_reg[15:8]
                                                 : sd_s2_reg[7:0]}),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  (rsp_rdata)
    );

    // Pin drive
    logic active, cmd_on, std_ok;
    logic smemr_reg, smemw_reg;
    assign active = (state_reg != ISABC_ST_IDLE) && !ext_master_dram;
    assign cmd_on = (state_reg == ISABC_ST_CMD) || (state_reg == ISABC_ST_WAIT);
    assign std_ok = (addr_reg[23:20] == 4'h0) || is_ref;

    assign bale_out = (state_reg == ISABC_ST_ADDR);
    assign aen_out  = active && (src_reg != ISABC_SRC_CPU);
    assign aen_oe   = !ext_dma_reg;
    assign sa_out   = is_io ? {4'h0, addr_reg[15:0]} : addr_reg[19:0];
    assign la_out   = addr_reg[23:17];
    assign addr_oe  = active;
    assign sbhe_n_out    = !(active && be_reg[1] && !is_ref);
    assign refresh_n_out = !(active && is_ref);
    assign memr_n_out = !(cmd_on && is_mem && is_rd);
    assign memw_n_out = !(cmd_on && is_mem && !is_rd);
    assign ior_n_out  = !(cmd_on && is_io && is_rd);
    assign iow_n_out  = !(cmd_on && is_io && !is_rd);
    assign cmd_oe     = active;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            smemr_reg <= 1'b0;
            smemw_reg <= 1'b0;
        end else if (clk_en) begin
            smemr_reg <= !memr_n_out && std_ok;
            smemw_reg <= !memw_n_out && std_ok;
        end
    end
    assign smemr_n_out = !smemr_reg;
    assign smemw_n_out = !smemw_reg;

    assign iochrdy_out  = ext_master_ready;
    assign iochrdy_oe   = ext_master_dram && !ext_master_ready;
    assign memcs16_n_out = 1'b0;
    assign memcs16_n_oe  = ext_master_dram;
    assign sd_out = wide_reg ? wdata_reg
                  : (be_reg[1] ? {wdata_reg[7:0], 8'h00} : wdata_reg);
    assign sd_oe  = cmd_on && !is_rd && active;

    logic nmi_reg;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nmi_reg <= 1'b0;
        end else if (clk_en) begin
            nmi_reg <= !chk_s[1] && nmi_chk_enable;
        end
    end
    assign nmi_out = nmi_reg;

    bale_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(memr_n_out) |-> $past(bale_out))
        else $error("command without preceding latch enable");
    aen_dma_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (active && src_reg == ISABC_SRC_DMA) |-> aen_out)
        else $error("address enable low in DMA cycle");
    aen_ref_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (active && is_ref) |-> (aen_out && !memr_n_out == cmd_on))
        else $error("refresh without address enable");
    clk_float_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !pg_q |-> !sysclk_oe)
        else $error("bus clock driven without power good");
    sbhe_ref_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !refresh_n_out |-> sbhe_n_out)
        else $error("byte high enable during refresh");
    std_delay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (clk_en && !memr_n_out && std_ok) |=> !smemr_n_out)
        else $error("standard read not a delayed copy");
    rdy_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (state_reg == ISABC_ST_WAIT && zws_s[1] && !rdy_s[1])
        |=> state_reg != ISABC_ST_END)
        else $error("cycle ended while not ready");
    la_sa_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (active && is_mem) |-> sa_out[19:17] == la_out[19:17])
        else $error("latched and unlatched address differ");
    cs16_drv_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ext_master_dram |-> (memcs16_n_oe && !memcs16_n_out))
        else $error("memory chip select 16 not pulled low");

    io_cycle_c: cover property (@(posedge sys_clk) !ior_n_out);
    ref_cycle_c: cover property (@(posedge sys_clk) !refresh_n_out);
    wait_cycle_c: cover property (@(posedge sys_clk)
        state_reg == ISABC_ST_WAIT && !rdy_s[1]);
    rsp_stall_c: cover property (@(posedge sys_clk) rsp_valid && !rsp_ready);

endmodule // isabc_cycle

`default_nettype wire

// File: test/isabc_slave_model.sv
`timescale 1ns/100ps
`default_nettype none

// Bus slave: wait states, width select, zero wait and read data
module isabc_slave_model (
    // Clock
    input  wire logic        sys_clk,
    // Commands and address from the device
    input  wire logic        memr_n,
    input  wire logic        memw_n,
    input  wire logic        ior_n,
    input  wire logic        iow_n,
    input  wire logic        refresh_n,
    input  wire logic [19:0] sa,
    // Behaviour chosen by the bench
    input  wire logic [7:0]  wait_cyc,
    input  wire logic        zero_ws,
    input  wire logic        io16,
    // Answers
    output logic             iochrdy,
    output logic             iocs16_n,
    output logic             zerows_n,
    output logic      [15:0] sd
);
    logic [7:0] cnt_reg;
    logic       act;

    assign act = !(memr_n && memw_n && ior_n && iow_n);

    initial begin
        cnt_reg = 8'h00;
        sd      = 16'h0000;
    end

    always @(posedge sys_clk) begin
        cnt_reg  <= act ? cnt_reg + 8'h01 : 8'h00;
        iochrdy  <= !act || (cnt_reg >= wait_cyc);
        zerows_n <= !(act && zero_ws && refresh_n);
        iocs16_n <= !io16;
        // Released lanes toggle so a stale word never looks valid
        if ((!memr_n || !ior_n) && refresh_n)
            sd <= sa[15:0] ^ 16'hA5C3;
        else
            sd <= ~sd;
    end
endmodule // isabc_slave_model

`default_nettype wire

// File: test/isa_bus_cycle_interface_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module isa_bus_cycle_interface_tb_top
    import isabc_pkg::*;
;
    isabc_cmd_t   req_cmd;
    isabc_src_t   req_src;
    logic         sys_clk, sys_rst, clk_en, power_good_input, tc_strap_in;
    logic         ext_dma_strap_en, req_valid, rsp_ready, ext_master_dram;
    logic         ext_master_ready, nmi_chk_enable, iochk_n_in, strap_lvl;
    logic         zws_cfg, io16_cfg, slv_rdy, cmd_lo;
    logic [23:0]  req_addr;
    logic [15:0]  req_wdata, rsp_rdata, sd_out, sd_in;
    logic [1:0]   req_byte_en;
    logic [7:0]   wait_cfg;
    logic         req_ready, rsp_valid, nmi_out, sysclk_out, sysclk_oe;
    logic         bale_out, aen_out, aen_oe, addr_oe, sbhe_n_out, cmd_oe;
    logic         refresh_n_out, memr_n_out, memw_n_out, smemr_n_out;
    logic         smemw_n_out, ior_n_out, iow_n_out, iochrdy_out, iochrdy_oe;
    logic         memcs16_n_out, memcs16_n_oe, sd_oe, sysclk_in, iochrdy_in;
    logic         iocs16_n_in, zerows_n_in;
    logic [19:0]  sa_out;
    logic [23:17] la_out;
    int           n_mismatch, num_checks, cyc, ext_mode, len_cmd;
    logic [31:0]  exp_q[$];

    assign clk_en     = 1'b1;
    assign sysclk_in  = sysclk_oe ? sysclk_out : strap_lvl;
    assign iochrdy_in = slv_rdy && (!iochrdy_oe || iochrdy_out);
    assign cmd_lo     = !(memr_n_out && memw_n_out && ior_n_out && iow_n_out);

    isabc_cycle DUT (
        .sys_clk, .sys_rst, .clk_en, .power_good_input, .ext_dma_strap_en,
        .tc_strap_in, .req_valid, .req_ready, .req_cmd, .req_src, .req_addr,
        .req_byte_en, .req_wdata, .rsp_valid, .rsp_ready, .rsp_rdata,
        .ext_master_dram, .ext_master_ready, .nmi_chk_enable, .nmi_out,
        .sysclk_in, .sysclk_out, .sysclk_oe, .bale_out, .aen_out, .aen_oe,
        .sa_out, .la_out, .addr_oe, .sbhe_n_out, .refresh_n_out, .memr_n_out,
        .memw_n_out, .smemr_n_out, .smemw_n_out, .ior_n_out, .iow_n_out,
        .cmd_oe, .iochrdy_in, .iochrdy_out, .iochrdy_oe, .iocs16_n_in,
        .zerows_n_in, .iochk_n_in, .memcs16_n_out, .memcs16_n_oe, .sd_in,
        .sd_out, .sd_oe
    );

    isabc_slave_model slave (
        .sys_clk(sys_clk), .memr_n(memr_n_out), .memw_n(memw_n_out),
        .ior_n(ior_n_out), .iow_n(iow_n_out), .refresh_n(refresh_n_out),
        .sa(sa_out), .wait_cyc(wait_cfg), .zero_ws(zws_cfg), .io16(io16_cfg),
        .iochrdy(slv_rdy), .iocs16_n(iocs16_n_in), .zerows_n(zerows_n_in),
        .sd(sd_in)
    );

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    function automatic logic [15:0] exp_rd(input logic [23:0] a);
        return a[15:0] ^ 16'hA5C3;
    endfunction

    task automatic wait_ready;
        for (int k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge sys_clk);
    endtask

    task automatic power_up(input logic div3, input logic tc);
        @(posedge sys_clk);
        strap_lvl   <= div3;
        tc_strap_in <= tc;
        @(posedge sys_clk);
        power_good_input <= 1'b1;
        wait_ready();
    endtask

    // Clocks between two rises of the bus clock
    task automatic bus_period(output int p);
        int   last;
        logic prev;
        last = -1;
        prev = 1'b1;
        p    = 0;
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk);
            if (sysclk_out === 1'b1 && prev === 1'b0) begin
                if (last >= 0)
                    p = i - last;
                last = i;
            end
            prev = sysclk_out;
        end
    endtask

    task automatic run_cyc(input isabc_cmd_t c, input isabc_src_t s,
                           input logic [23:0] a, input logic [1:0] be,
                           input logic [15:0] wd);
        logic        pre_bale, aen_seen, std_seen, bad, went, mem, rfr;
        logic [3:0]  cmd_v, cmd_x;
        logic [15:0] wdat, m;
        pre_bale = 1'b0;
        aen_seen = 1'b0;
        std_seen = 1'b0;
        bad      = 1'b0;
        went     = 1'b0;
        cmd_v    = 4'hF;
        wdat     = 16'h0000;
        len_cmd  = 0;
        m        = be[1] ? 16'hFFFF : 16'h00FF;
        mem      = (c == ISABC_CMD_MEM_RD || c == ISABC_CMD_MEM_WR);
        rfr      = (s == ISABC_SRC_REFRESH);
        cmd_x    = ~(4'h1 << c);
        wait_ready();
        @(posedge sys_clk);
        req_valid   <= 1'b1;
        req_cmd     <= c;
        req_src     <= s;
        req_addr    <= a;
        req_byte_en <= be;
        req_wdata   <= wd;
        for (int k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge sys_clk);
        @(posedge sys_clk);
        req_valid <= 1'b0;
        for (int k = 0; k < 300; k++) begin
            @(negedge sys_clk);
            if (!cmd_lo && went)
                break;
            if (!cmd_lo && bale_out)
                pre_bale = 1'b1;
            aen_seen |= aen_out && aen_oe;
            if (cmd_lo) begin
                went = 1'b1;
                len_cmd++;
                cmd_v = {iow_n_out, ior_n_out, memw_n_out, memr_n_out};
                bad |= sbhe_n_out !== (!be[1] || rfr);
                bad |= refresh_n_out !== !rfr;
                bad |= mem && la_out[19:17] !== sa_out[19:17];
                bad |= len_cmd == 1 && !(smemr_n_out && smemw_n_out);
                std_seen |= !(smemr_n_out && smemw_n_out);
                if (sd_oe)
                    wdat = sd_out;
            end
        end
        chk(pre_bale, 1'b1);
        chk(aen_seen, !(s == ISABC_SRC_CPU) && ext_mode == 0);
        chk(bad, 1'b0);
        chk(cmd_v, cmd_x);
        if (mem && !rfr)
            chk(std_seen, a[23:20] == 4'h0);
        if (!rfr && (c == ISABC_CMD_MEM_WR || c == ISABC_CMD_IO_WR))
            chk(wdat & m, wd & m);
        if (!rfr && (c == ISABC_CMD_MEM_RD || c == ISABC_CMD_IO_RD))
            exp_q.push_back({m, exp_rd(a) & m});
    endtask

    // Takes each answer late so the buffer must hold it
    task automatic drain;
        logic [31:0] e;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            for (int k = 0; k < 300 && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
            repeat (3) @(negedge sys_clk);
            chk(rsp_valid, 1'b1);
            chk(rsp_rdata & e[31:16], e[15:0]);
            @(posedge sys_clk);
            rsp_ready <= 1'b1;
            @(posedge sys_clk);
            rsp_ready <= 1'b0;
        end
    endtask

    initial begin
        int          p;
        int          lens[9];
        logic [23:0] a;
        logic [1:0]  be;
        isabc_cmd_t  c;
        void'($urandom(87048));
        {sys_rst, ext_dma_strap_en, iochk_n_in} = 3'h7;
        {power_good_input, tc_strap_in, req_valid, rsp_ready} = 4'h0;
        {ext_master_dram, ext_master_ready, nmi_chk_enable} = 3'h0;
        {strap_lvl, zws_cfg, io16_cfg} = 3'h0;
        req_cmd = ISABC_CMD_MEM_RD;
        req_src = ISABC_SRC_CPU;
        {req_addr, req_byte_en, req_wdata, wait_cfg} = 50'h0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(sysclk_oe, 1'b0);
        power_up(1'b0, 1'b1);
        bus_period(p);
        chk(p, 4);
        for (int i = 0; i < 16; i++) begin
            a = 24'($urandom);
            if (i[0])
                a[23:20] = 4'h0;
            be = $urandom_range(1) ? 2'h3 : 2'h1;
            io16_cfg <= be[1];
            wait_cfg <= 8'($urandom_range(6));
            run_cyc(isabc_cmd_t'(i[1:0]), isabc_src_t'({1'b0, i[2]}), a, be,
                    16'($urandom));
            if (exp_q.size() == 2)
                drain();
        end
        drain();
        run_cyc(ISABC_CMD_MEM_RD, ISABC_SRC_REFRESH, 24'h000000, 2'h3, 16'h0);
        // Cycle lengths: zero wait pairs, then a slave holding ready low
        for (int i = 0; i < 9; i++) begin
            c  = (i < 4 || i == 8) ? ISABC_CMD_MEM_RD :
                 (i < 6 ? ISABC_CMD_IO_RD : ISABC_CMD_IO_WR);
            be = (i == 2 || i == 3 || i == 6 || i == 7) ? 2'h1 : 2'h3;
            zws_cfg  <= i[0];
            io16_cfg <= be[1];
            wait_cfg <= (i == 8) ? 8'h18 : 8'h00;
            run_cyc(c, ISABC_SRC_CPU, 24'h0A0000 + 24'(i * 2), be, 16'h5A3C);
            lens[i] = len_cmd;
            drain();
        end
        chk(lens[1] < lens[0], 1'b1);
        chk(lens[3] < lens[2], 1'b1);
        chk(lens[7] < lens[6], 1'b1);
        chk(lens[5] == lens[4], 1'b1);
        chk(lens[8] >= 24 && lens[8] > lens[0], 1'b1);
        @(posedge sys_clk);
        ext_master_dram <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk(req_ready, 1'b0);
        chk({iochrdy_oe, iochrdy_out, memcs16_n_oe, memcs16_n_out}, 4'hA);
        @(posedge sys_clk);
        ext_master_ready <= 1'b1;
        @(negedge sys_clk);
        chk(iochrdy_out, 1'b1);
        @(posedge sys_clk);
        ext_master_dram <= 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(iochrdy_oe, 1'b0);
        @(posedge sys_clk);
        nmi_chk_enable <= 1'b1;
        iochk_n_in     <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(nmi_out, 1'b1);
        @(posedge sys_clk);
        nmi_chk_enable <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(nmi_out, 1'b0);
        @(posedge sys_clk);
        iochk_n_in       <= 1'b1;
        power_good_input <= 1'b0;
        repeat (5) @(negedge sys_clk);
        chk(sysclk_oe, 1'b0);
        power_up(1'b1, 1'b0);
        ext_mode = 1;
        bus_period(p);
        chk(p, 3);
        chk(aen_oe, 1'b0);
        run_cyc(ISABC_CMD_MEM_WR, ISABC_SRC_DMA, 24'h012345, 2'h3, 16'($urandom));
        tally_and_finish();
    end
endmodule // isa_bus_cycle_interface_tb_top

`default_nettype wire
